/* rtl/ast_pkg.sv */
package ast_pkg;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS  = 3'h1;
    localparam logic [2:0] ADDR_CONFIG  = 3'h2;
    localparam logic [2:0] ADDR_TXDATA  = 3'h3;
    localparam logic [2:0] ADDR_RXDATA  = 3'h4;
    // Control bits
    localparam int CTL_TXEN   = 0;
    localparam int CTL_MODE0  = 1;
    localparam int CTL_PAREN  = 3;
    localparam int CTL_EVEN   = 4;
    localparam int CTL_TXIE   = 5;
    localparam int CTL_ERRIE  = 6;
    localparam int CTL_RXIE   = 7;
    localparam int CTL_TXBUF  = 8;
    // Status bits
    localparam int STS_RXEN   = 0;
    localparam int STS_RXFULL = 1;
    localparam int STS_PERR   = 2;
    localparam int STS_OVERRUN_ERROR_FLAG  = 3;
    localparam int STS_FERR   = 4;
    localparam int STS_TXBUSY = 5;
    localparam int STS_TXDONE = 6;
    localparam logic [1:0] MODE_7 = 2'h1;
    localparam logic [1:0] MODE_8 = 2'h2;
    localparam logic [1:0] MODE_9 = 2'h3;
    localparam int OVS       = 16;
    localparam int OVS_MID   = 7;
    localparam int CLK_MHZ   = 250;
    localparam int BAUD_BASE = 9600;
    localparam int DIV_BASE  = (CLK_MHZ * 1000000) / (BAUD_BASE * OVS);
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ast_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ast_rx_t;
endpackage

/* rtl/ast_uart.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ast_uart import ast_pkg::*; #(
    parameter int DIV_BASE_P = DIV_BASE
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    // Serial line
    input  wire logic        rxPin,
    output logic             txPin,
    // Requests
    output logic             txDoneIrq,
    output logic             rxIrq,
    output logic             rxErrorIrq
);
    initial begin
        if (DIV_BASE_P < 1) $error("DIV_BASE_P must be at least one");
    end

    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    logic rstA_ff, rstB_ff, rxA_ff, rxB_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstA_ff <= 1'b0;
            rstB_ff <= 1'b0;
        end else begin
            rstA_ff <= 1'b1;
            rstB_ff <= rstA_ff;
        end
    end
    wire logic rstN = rstB_ff;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxA_ff <= 1'b1;
            rxB_ff <= 1'b1;
        end else begin
            rxA_ff <= rxPin;
            rxB_ff <= rxA_ff;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic       txEn_ff, parEn_ff, even_ff, txIe_ff, errIe_ff, rxIe_ff, rxEn_ff;
    logic [1:0] mode_ff;
    logic [2:0] baudSel_ff;
    logic [8:0] txHold_ff, rxData_ff;
    logic       txBufFlag_ff, rxFull_ff, perr_ff, overrun_error_flag_ff, ferr_ff, txDoneSt_ff;
    ast_tx_t    txState_ff;
    ast_rx_t    rxState_ff;
    logic       txLoad, rxDone, rxPerr, rxFerr, txStopEnd;

    function automatic logic parBit(input logic [8:0] d, input logic [1:0] m, input logic ev);
        logic p;
        p = ^d[6:0] ^ (m != MODE_7 && d[7]);
        return ev ? p : ~p;
    endfunction
    function automatic logic [3:0] nBits(input logic [1:0] m);
        return (m == MODE_7) ? 4'h7 : (m == MODE_9) ? 4'h9 : 4'h8;
    endfunction
    wire logic parOn = parEn_ff && (mode_ff != MODE_9);

    wire logic wrCtl = regWr && regAddr == ADDR_CONTROL;
    wire logic wrSts = regWr && regAddr == ADDR_STATUS;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txEn_ff <= 1'b0; mode_ff <= MODE_8; parEn_ff <= 1'b0; even_ff <= 1'b0;
            txIe_ff <= 1'b0; errIe_ff <= 1'b0; rxIe_ff <= 1'b0; rxEn_ff <= 1'b0;
            baudSel_ff <= 3'h0;
        end else begin
            if (wrCtl) begin
                txEn_ff  <= regWdata[CTL_TXEN];
                mode_ff  <= regWdata[CTL_MODE0+:2];
                parEn_ff <= regWdata[CTL_PAREN];
                even_ff  <= regWdata[CTL_EVEN];
                txIe_ff  <= regWdata[CTL_TXIE];
                errIe_ff <= regWdata[CTL_ERRIE];
                rxIe_ff  <= regWdata[CTL_RXIE];
            end
            if (wrSts) rxEn_ff <= regWdata[STS_RXEN];
            if (regWr && regAddr == ADDR_CONFIG) baudSel_ff <= regWdata[2:0];
        end
    end

    // Transmit buffer: flag set on write wins over drain
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txHold_ff <= 9'h000; txBufFlag_ff <= 1'b0;
        end else if (regWr && regAddr == ADDR_TXDATA) begin
            txHold_ff <= regWdata[8:0];
            txBufFlag_ff <= 1'b1;
        end else if (txLoad) begin
            txBufFlag_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Baud generator: 16x oversample tick
    // ------------------------------------------------------------
    logic [23:0] baudCnt_ff;
    logic        tick_ff;
    wire logic [23:0] divVal = 24'(DIV_BASE_P) << baudSel_ff;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            baudCnt_ff <= 24'h000000; tick_ff <= 1'b0;
        end else if (baudCnt_ff >= divVal - 24'h000001) begin
            baudCnt_ff <= 24'h000000; tick_ff <= 1'b1;
        end else begin
            baudCnt_ff <= baudCnt_ff + 24'h000001; tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [3:0] txOvs_ff, txIdx_ff;
    logic [8:0] txShift_ff;
    logic       txPar_ff;
    assign txLoad = txState_ff == TX_IDLE && txBufFlag_ff && txEn_ff;
    wire logic txBitEnd = tick_ff && txOvs_ff == 4'(OVS - 1);
    assign txStopEnd = txState_ff == TX_STOP && txBitEnd;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txState_ff <= TX_IDLE; txOvs_ff <= 4'h0; txIdx_ff <= 4'h0;
            txShift_ff <= 9'h000; txPar_ff <= 1'b0; txPin <= 1'b1;
        end else begin
            if (tick_ff) txOvs_ff <= txOvs_ff + 4'h1;
            case (txState_ff)
                TX_IDLE: begin
                    txPin <= 1'b1;
                    if (txLoad) begin
                        txShift_ff <= txHold_ff;
                        txPar_ff <= parBit(txHold_ff, mode_ff, even_ff);
                        txState_ff <= TX_START; txOvs_ff <= 4'h0; txPin <= 1'b0;
                    end
                end
                TX_START: if (txBitEnd) begin
                    txState_ff <= TX_DATA; txIdx_ff <= 4'h0; txPin <= txShift_ff[0];
                end
                TX_DATA: if (txBitEnd) begin
                    txShift_ff <= txShift_ff >> 1;
                    txIdx_ff <= txIdx_ff + 4'h1;
                    if (txIdx_ff == nBits(mode_ff) - 4'h1) begin
                        txState_ff <= parOn ? TX_PAR : TX_STOP;
                        txPin <= parOn ? txPar_ff : 1'b1;
                    end else txPin <= txShift_ff[1];
                end
                TX_PAR: if (txBitEnd) begin
                    txState_ff <= TX_STOP; txPin <= 1'b1;
                end
                TX_STOP: if (txBitEnd) txState_ff <= TX_IDLE;
                default: txState_ff <= TX_IDLE;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) txDoneSt_ff <= 1'b0;
        else if (txStopEnd) txDoneSt_ff <= 1'b1;
        else if (wrCtl && regWdata[CTL_TXBUF]) txDoneSt_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [3:0] rxOvs_ff, rxIdx_ff;
    logic [8:0] rxShift_ff;
    logic [1:0] startLow_ff;
    logic       rxParIn_ff, rxPrev_ff;
    wire logic rxSample = tick_ff && rxOvs_ff == 4'(OVS_MID);
    wire logic rxEnd = tick_ff && rxOvs_ff == 4'(OVS - 1);
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxState_ff <= RX_IDLE; rxOvs_ff <= 4'h0; rxIdx_ff <= 4'h0; rxShift_ff <= 9'h000;
            startLow_ff <= 2'h0; rxParIn_ff <= 1'b0; rxPrev_ff <= 1'b1;
            rxDone <= 1'b0; rxPerr <= 1'b0; rxFerr <= 1'b0;
        end else begin
            rxPrev_ff <= rxB_ff;
            rxDone <= 1'b0;
            if (tick_ff) rxOvs_ff <= rxOvs_ff + 4'h1;
            case (rxState_ff)
                RX_IDLE: if (rxEn_ff && rxPrev_ff && !rxB_ff) begin
                    rxState_ff <= RX_START; rxOvs_ff <= 4'h0; startLow_ff <= 2'h0;
                end
                RX_START: begin
                    // Three samples around mid-bit, majority low
                    if (tick_ff && rxOvs_ff >= 4'(OVS_MID - 1) && rxOvs_ff <= 4'(OVS_MID + 1) && !rxB_ff)
                        startLow_ff <= startLow_ff + 2'h1;
                    if (rxEnd) begin
                        if (startLow_ff >= 2'h2) begin
                            rxState_ff <= RX_DATA; rxIdx_ff <= 4'h0;
                        end else rxState_ff <= RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (rxSample) rxShift_ff <= {rxB_ff, rxShift_ff[8:1]};
                    if (rxEnd) begin
                        rxIdx_ff <= rxIdx_ff + 4'h1;
                        if (rxIdx_ff == nBits(mode_ff) - 4'h1) rxState_ff <= parOn ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (rxSample) rxParIn_ff <= rxB_ff;
                    if (rxEnd) rxState_ff <= RX_STOP;
                end
                RX_STOP: if (rxSample) begin
                    rxDone <= 1'b1;
                    rxFerr <= !rxB_ff;
                    rxPerr <= parOn && (rxParIn_ff != parBit(rxShift_ff >> (4'h9 - nBits(mode_ff)),
                                                            mode_ff, even_ff));
                    rxState_ff <= RX_IDLE;
                end
                default: rxState_ff <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer and flags; sets win over clears
    wire logic rdRx = regRd && regAddr == ADDR_RXDATA;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxData_ff <= 9'h000; rxFull_ff <= 1'b0;
            perr_ff <= 1'b0; overrun_error_flag_ff <= 1'b0; ferr_ff <= 1'b0;
        end else begin
            if (rxDone) begin
                rxData_ff <= rxShift_ff >> (4'h9 - nBits(mode_ff));
                rxFull_ff <= 1'b1;
            end else if (rdRx) rxFull_ff <= 1'b0;
            if (rxDone && rxPerr) perr_ff <= 1'b1;
            else if (wrSts && !regWdata[STS_PERR]) perr_ff <= 1'b0;
            if (rxDone && rxFull_ff && !rdRx) overrun_error_flag_ff <= 1'b1;
            else if (wrSts && !regWdata[STS_OVERRUN_ERROR_FLAG]) overrun_error_flag_ff <= 1'b0;
            if (rxDone && rxFerr) ferr_ff <= 1'b1;
            else if (wrSts && !regWdata[STS_FERR]) ferr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Requests and read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txDoneIrq <= 1'b0; rxIrq <= 1'b0; rxErrorIrq <= 1'b0;
        end else begin
            txDoneIrq <= txStopEnd && txIe_ff;
            rxIrq <= rxDone && rxIe_ff;
            // Any check fail or stale flag fires on each byte
            rxErrorIrq <= rxDone && errIe_ff &&
                          (rxPerr || rxFerr || rxFull_ff || perr_ff || overrun_error_flag_ff || ferr_ff);
        end
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) regRdata <= 16'h0000;
        else if (regRd) begin
            case (regAddr)
                ADDR_CONTROL: regRdata <= {7'h00, txBufFlag_ff, rxIe_ff, errIe_ff, txIe_ff, even_ff,
                                           parEn_ff, mode_ff, txEn_ff};
                ADDR_STATUS:  regRdata <= {9'h000, txDoneSt_ff, txState_ff != TX_IDLE, ferr_ff,
                                           overrun_error_flag_ff, perr_ff, rxFull_ff, rxEn_ff};
                ADDR_CONFIG:  regRdata <= {13'h0000, baudSel_ff};
                ADDR_RXDATA:  regRdata <= {7'h00, rxData_ff};
                default:      regRdata <= 16'h0000;
            endcase
        end else regRdata <= 16'h0000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (!rstN)
        txState_ff == TX_IDLE && !$past(txLoad) |-> txPin) else $error("line not idle high");
    AST_START_LOW: assert property (@(posedge mclk) disable iff (!rstN)
        txLoad |=> !txPin && txState_ff == TX_START) else $error("no start bit");
    AST_TXEN: assert property (@(posedge mclk) disable iff (!rstN)
        txState_ff == TX_IDLE && !txEn_ff |=> txState_ff == TX_IDLE && txPin) else $error("sent while disabled");
    AST_TXBUF: assert property (@(posedge mclk) disable iff (!rstN)
        regWr && regAddr == ADDR_TXDATA |=> txBufFlag_ff) else $error("buffer flag not set");
    AST_STOP_HIGH: assert property (@(posedge mclk) disable iff (!rstN)
        txState_ff == TX_STOP |-> txPin) else $error("stop bit low");
    AST_TXIRQ: assert property (@(posedge mclk) disable iff (!rstN)
        txStopEnd && txIe_ff |=> txDoneIrq) else $error("no tx done request");
    AST_RXFULL: assert property (@(posedge mclk) disable iff (!rstN)
        rxDone |=> rxFull_ff) else $error("rx full not set");
    AST_RDCLR: assert property (@(posedge mclk) disable iff (!rstN)
        rdRx && !rxDone |=> !rxFull_ff) else $error("read did not clear full");
    AST_OVERRUN: assert property (@(posedge mclk) disable iff (!rstN)
        rxDone && rxFull_ff && !rdRx |=> overrun_error_flag_ff) else $error("overrun missed");
    AST_FRAME: assert property (@(posedge mclk) disable iff (!rstN)
        rxDone && rxFerr |=> ferr_ff) else $error("framing error missed");
    AST_ERRIRQ: assert property (@(posedge mclk) disable iff (!rstN)
        rxDone && errIe_ff && rxPerr |=> rxErrorIrq) else $error("no error request");
    AST_NOPAR9: assert property (@(posedge mclk) disable iff (!rstN)
        mode_ff == MODE_9 |-> txState_ff != TX_PAR) else $error("parity in third mode");
    COV_TX: cover property (@(posedge mclk) disable iff (!rstN) txStopEnd);
    COV_RX: cover property (@(posedge mclk) disable iff (!rstN) rxDone && !rxFerr);
    COV_OVR: cover property (@(posedge mclk) disable iff (!rstN) rxDone && rxFull_ff);
endmodule
`default_nettype wire

/* testbench/ast_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
    // Clock
    input  wire logic        mclk,
    // Serial lines
    input  wire logic        txPin,
    output logic             rxPin,
    // Bit time and frame length
    input  wire logic [15:0] bitC,
    input  wire logic [3:0]  fLen,
    // Captured frame, start level in bit 11
    output logic      [11:0] frameBits,
    output logic             frameStb
);
    logic [11:0] cap;
    initial begin
        rxPin     = 1'b1;
        frameStb  = 1'b0;
        frameBits = 12'h000;
    end
    // ----
    // Frame decoder, mid-bit sampling
    // ----
    always begin
        @(negedge txPin);
        repeat (bitC / 2) @(posedge mclk);
        cap     = 12'h000;
        cap[11] = txPin;
        for (int i = 0; i < fLen; i++) begin
            repeat (bitC) @(posedge mclk);
            cap[i] = txPin;
        end
        frameBits <= cap;
        frameStb  <= 1'b1;
        @(posedge mclk);
        frameStb  <= 1'b0;
    end
    // ----
    // Frame sender
    // ----
    task automatic sendChar(input logic [8:0] d, input int nb, input logic pe,
                            input logic pb, input logic sb);
        @(posedge mclk);
        rxPin <= 1'b0;
        repeat (bitC) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            rxPin <= d[i];
            repeat (bitC) @(posedge mclk);
        end
        if (pe) begin
            rxPin <= pb;
            repeat (bitC) @(posedge mclk);
        end
        rxPin <= sb;
        repeat (bitC) @(posedge mclk);
        rxPin <= 1'b1;
    endtask
    task automatic glitch(input int n);
        @(posedge mclk);
        rxPin <= 1'b0;
        repeat (n) @(posedge mclk);
        rxPin <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* testbench/async_serial_transceiver_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module async_serial_transceiver_tb import ast_pkg::*;;
    // ----
    // Signals
    // ----
    logic        mclk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [15:0] regWdata = 16'h0000, regRdata, expRd, bitC = 16'h0010;
    logic        rxPin, txPin, txDoneIrq, rxIrq, rxErrorIrq, frameStb;
    logic        rdPend = 1'b0, lowSeen = 1'b0;
    logic [3:0]  fLen = 4'h9;
    logic [11:0] frameBits, expFr;
    logic [15:0] rdQ[$];
    logic [11:0] txQ[$];
    int failures = 0, checks = 0, cycles = 0, seed = 16679, base = 0;
    int txCnt = 0, rxCnt = 0, errCnt = 0, expTx = 0, expRx = 0;
    always #2 mclk = ~mclk;
    ast_uart #(.DIV_BASE_P(1)) ast_uart_inst (.mclk, .reset_n, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .rxPin, .txPin, .txDoneIrq, .rxIrq, .rxErrorIrq);
    ast_peer ast_peer_inst (.mclk, .txPin, .rxPin, .bitC, .fLen, .frameBits, .frameStb);
    // ----
    // Helpers
    // ----
    function automatic logic [15:0] ctl(input logic en, input logic [1:0] m, input logic p, input logic ev);
        return 16'h00E0 | 16'(en) | (16'(m) << 1) | (16'(p) << 3) | (16'(ev) << 4);
    endfunction
    function automatic logic par(input logic [8:0] d, input logic ev);
        return ev ? ^d : ~^d;
    endfunction
    function automatic logic [11:0] frame(input logic [8:0] d, input int nb, input logic pe, input logic pb);
        logic [11:0] f;
        f = 12'(d) & ((12'h001 << nb) - 12'h001);
        if (pe) f[nb] = pb;
        f[nb + 32'(pe)] = 1'b1;
        return f;
    endfunction
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk);
        rdQ.push_back(e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
    endtask
    task automatic txChar(input logic [8:0] d, input int nb, input logic pe, input logic pb);
        txQ.push_back(frame(d, nb, pe, pb));
        wr(ADDR_TXDATA, 16'(d));
    endtask
    task automatic waitTx();
        while (txQ.size() > 0) @(posedge mclk);
        repeat (2 * bitC) @(posedge mclk);
    endtask
    task automatic rxChar(input logic [8:0] d, input int nb, input logic pe, input logic pb, input logic sb);
        ast_peer_inst.sendChar(d, nb, pe, pb, sb);
        repeat (bitC) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----
    // Watcher
    // ----
    always @(posedge mclk) begin
        cycles++;
        rdPend <= regRd;
        if (rdPend) begin
            expRd = rdQ.pop_front();
            `CHK("read data", expRd, regRdata)
        end
        if (frameStb === 1'b1) begin
            expFr = txQ.pop_front();
            `CHK("tx frame", expFr, frameBits)
        end
        txCnt += int'(txDoneIrq === 1'b1);
        rxCnt += int'(rxIrq === 1'b1);
        errCnt += int'(rxErrorIrq === 1'b1);
        if (txPin !== 1'b1) lowSeen = 1'b1;
        if (cycles == 40000) begin
            failures++;
            summarize();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        logic [8:0] d, d2;
        int nb;
        logic pe;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(ADDR_CONTROL, 16'h0004);
        rd(ADDR_STATUS, 16'h0000);
        wr(3'h5, 16'hFFFF);
        rd(ADDR_CONFIG, 16'h0000);
        rd(3'h5, 16'h0000);
        wr(ADDR_STATUS, 16'h0001);
        wr(ADDR_CONTROL, ctl(0, MODE_8, 0, 0));
        lowSeen = 1'b0;
        txChar(9'h0A5, 8, 0, 0);
        rd(ADDR_CONTROL, ctl(0, MODE_8, 0, 0) | 16'h0100);
        repeat (64) @(posedge mclk);
        `CHK("tx held idle", 1'b0, lowSeen)
        wr(ADDR_CONTROL, ctl(1, MODE_8, 0, 0));
        waitTx();
        expTx++;
        `CHK("tx done irq", expTx, txCnt)
        for (int m = 1; m <= 3; m++)
            for (int p = 0; p < 4; p++) begin
                nb = (m == 1) ? 7 : (m == 2) ? 8 : 9;
                pe = p[1] && m != 3;
                fLen = 4'(nb + 32'(pe) + 1);
                wr(ADDR_CONTROL, ctl(1, 2'(m), p[1], p[0]));
                d = 9'($random(seed)) & 9'((1 << nb) - 1);
                d2 = 9'($random(seed)) & 9'((1 << nb) - 1);
                fork
                    begin
                        txChar(d, nb, pe, par(d, p[0]));
                        txChar(d2, nb, pe, par(d2, p[0]));
                    end
                    rxChar(d2, nb, pe, par(d2, p[0]), 1'b1);
                join
                waitTx();
                expTx += 2;
                expRx++;
                `CHK("tx done irq", expTx, txCnt)
                `CHK("rx irq", expRx, rxCnt)
                rd(ADDR_STATUS, 16'h0043);
                rd(ADDR_RXDATA, 16'(d2));
                rd(ADDR_STATUS, 16'h0041);
            end
        `CHK("err irq", 0, errCnt)
        fLen = 4'h9;
        wr(ADDR_CONTROL, ctl(0, MODE_8, 1, 1) | 16'h0100);
        d = 9'h0C3;
        rxChar(d, 8, 1, ~par(d, 1), 1'b1);
        rd(ADDR_STATUS, 16'h0007);
        rd(ADDR_RXDATA, 16'(d));
        rxChar(d, 8, 1, par(d, 1), 1'b1);
        `CHK("err irq", 2, errCnt)
        rd(ADDR_STATUS, 16'h0007);
        rd(ADDR_RXDATA, 16'(d));
        wr(ADDR_STATUS, 16'h0001);
        rd(ADDR_STATUS, 16'h0001);
        rxChar(d, 8, 1, par(d, 1), 1'b0);
        rd(ADDR_STATUS, 16'h0013);
        rd(ADDR_RXDATA, 16'(d));
        wr(ADDR_STATUS, 16'h0001);
        rxChar(d, 8, 1, par(d, 1), 1'b1);
        rxChar(d, 8, 1, par(d, 1), 1'b1);
        rd(ADDR_STATUS, 16'h000B);
        `CHK("err irq", 4, errCnt)
        rd(ADDR_RXDATA, 16'(d));
        wr(ADDR_STATUS, 16'h0001);
        base = rxCnt;
        ast_peer_inst.glitch(3);
        repeat (64) @(posedge mclk);
        `CHK("rx irq", base, rxCnt)
        rxChar(9'h05A, 8, 1, par(9'h05A, 1), 1'b1);
        rd(ADDR_STATUS, 16'h0003);
        rd(ADDR_RXDATA, 16'h005A);
        wr(ADDR_STATUS, 16'h0000);
        rxChar(9'h033, 8, 1, par(9'h033, 1), 1'b1);
        rd(ADDR_STATUS, 16'h0000);
        wr(ADDR_STATUS, 16'h0001);
        wr(ADDR_CONFIG, 16'h0001);
        bitC = 16'h0020;
        wr(ADDR_CONTROL, ctl(1, MODE_8, 0, 0));
        d = 9'($random(seed)) & 9'h0FF;
        fork
            txChar(d, 8, 0, 0);
            rxChar(d, 8, 0, 0, 1'b1);
        join
        waitTx();
        rd(ADDR_RXDATA, 16'(d));
        summarize();
    end
endmodule
`default_nettype wire
